//--- lbs_far_model.sv
// Far-side model: bus arbiter and foreign master on the local bus
`timescale 1ns/1ps
`default_nettype none
module lbs_far_model
    import lbs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_bus_request_n,
    input wire logic i_strobe_n,
    input wire logic i_strobe_oe_n,
    input wire logic i_owner_n,
    input wire logic i_owner_oe_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_qual_oe_n,
    output logic o_bus_grant_n,
    output logic o_strobe_pin_n,
    output logic o_owner_pin_n,
    output logic [ADDR_W-1:0] o_addr_pin,
    output logic o_register_select_n,
    output logic o_bridge_select_n
);
    int grant_dly = 1;
    logic ext_busy = 1'b0;
    logic ext_strb_n = 1'b1;
    logic ext_drv = 1'b0;
    logic [ADDR_W-1:0] ext_addr = '0;
    logic [ADDR_W-1:0] last_addr = '0;

    // ========================================================
    // Shared pins; pull-ups hold strobe and owner high when free
    assign o_strobe_pin_n = !i_strobe_oe_n ? i_strobe_n : ext_strb_n;
    assign o_owner_pin_n = !i_owner_oe_n ? i_owner_n : !ext_busy;
    // Free address pins show the inverse of the last value, never a stale copy
    assign o_addr_pin = !i_qual_oe_n ? i_addr : (ext_drv ? ext_addr : ~last_addr);
    always @(negedge i_clk) begin
        if (!i_qual_oe_n || ext_drv) begin
            last_addr <= o_addr_pin;
        end
    end

    // ========================================================
    // Arbiter: grant after a delay, hold it until the design owns the bus
    initial begin
        o_bus_grant_n = 1'b1;
        o_register_select_n = 1'b1;
        o_bridge_select_n = 1'b1;
        forever begin
            @(negedge i_clk);
            if (i_bus_request_n === 1'b0) begin
                repeat (grant_dly) @(negedge i_clk);
                o_bus_grant_n <= 1'b0;
                while (i_owner_oe_n !== 1'b0) @(negedge i_clk);
                o_bus_grant_n <= 1'b1;
            end
        end
    end

    // ========================================================
    // Foreign master cycle; a late select arrives two cycles into the strobe
    task automatic slave_cycle(input logic [ADDR_W-1:0] a, input logic rs_n,
                               input logic bs_n, input logic late);
        @(negedge i_clk);
        ext_strb_n <= 1'b0;
        ext_drv <= 1'b1;
        ext_addr <= a;
        o_register_select_n <= late | rs_n;
        o_bridge_select_n <= late | bs_n;
        if (late) begin
            repeat (2) @(negedge i_clk);
            o_register_select_n <= rs_n;
            o_bridge_select_n <= bs_n;
        end
        repeat (5) @(negedge i_clk);
        ext_strb_n <= 1'b1;
        ext_drv <= 1'b0;
        o_register_select_n <= 1'b1;
        o_bridge_select_n <= 1'b1;
    endtask
endmodule // lbs_far_model
`default_nettype wire

//--- lbs_pin_sync.sv
// Two-stage falling-edge sampler for pins, with optional rising-edge second stage
`timescale 1ns/1ps
`default_nettype none
module lbs_pin_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_sync_mode,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2_fall;
    logic [W-1:0] stage2_rise;

    // ========================================================
    // First and second falling-edge stages; stage1 feeds flops only
    always_ff @(negedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage1 <= '1;
            stage2_fall <= '1;
        end else begin
            stage1 <= i_d;
            stage2_fall <= stage1;
        end
    end

    // Synchronous option: second stage on the rising edge, half a clock sooner
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage2_rise <= '1;
        end else begin
            stage2_rise <= stage1;
        end
    end

    assign o_q = i_sync_mode ? stage2_rise : stage2_fall;
endmodule // lbs_pin_sync
`default_nettype wire

//--- lbs_pkg.sv
// Constants and types for the local bus strobe and arbitration logic
package lbs_pkg;
    // ========================================================
    // Bus field widths
    localparam int ADDR_W = 32;
    localparam int TC_W = 4;
    localparam int SIZE_W = 2;
    localparam int REG_DEC_W = 12;
    localparam int SLV_SYNC_W = ADDR_W + 3;
    localparam int ARB_SYNC_W = 2;

    // ========================================================
    // Slave sample vector field positions
    localparam int SLV_STRB_POS = 0;
    localparam int SLV_REGSEL_POS = 1;
    localparam int SLV_BRSEL_POS = 2;
    localparam int SLV_ADDR_LSB = 3;

    // ========================================================
    // Arbitration sample vector field positions
    localparam int ARB_GRANT_POS = 0;
    localparam int ARB_BUSY_POS = 1;

    // ========================================================
    // Reset values and strap timing
    localparam logic PIN_NEGATED = 1'b1;
    localparam logic OE_OFF_N = 1'b1;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [1:0] STRAP_CNT_RST = 2'h0;

    // ========================================================
    // Master sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_REQ  = 6'h02,
        ST_OWN  = 6'h04,
        ST_ADDR = 6'h08,
        ST_STRB = 6'h10,
        ST_NEG  = 6'h20
    } lbs_state_t;
endpackage : lbs_pkg

//--- lbs_strobe_arb.sv
// Local bus strobe, slave qualification and bus arbitration logic
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Drive address strobe only while bus master; otherwise release it.
// RULE2: As master, address strobe goes low after a falling clock edge.
// RULE3: Address and qualifiers driven from the rising edge before strobe assertion.
// RULE4: Drive strobe high before releasing it.
// RULE5: When another master owns the bus, sample strobe on falling edges.
// RULE6: Accept slave cycle only with a select low together with strobe low.
// RULE7: Slave qualifiers need not be valid when strobe first asserts.
// RULE8: As master, assert bus-owner line from a falling clock edge.
// RULE9: Drive bus-owner line high before releasing it.
// RULE10: Bus-owner input is double-sampled on falling edges before use.
// RULE11: Ownership by request, grant, and bus-owner handshake.
// RULE12: Optional synchronous handling of arbitration inputs.
// RULE13: Strap sampled at reset selects legacy or burst-capable master protocol. Here it only sets o_alt_protocol; the sequencer ignores it.
// RULE14: In legacy protocol the strap pin is ignored after reset.
// RULE15: Slave address captured on the same falling edge as strobe.
// RULE16: Register accesses decode only the low twelve address bits.
// RULE17: External master asserts bridge select for far-side bus cycles.
// RULE18: Drive strobe and qualifiers only after grant and bus-owner assertion.
module lbs_strobe_arb
    import lbs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_sync_arb,
    input wire logic i_mst_req,
    input wire logic [ADDR_W-1:0] i_mst_addr,
    input wire logic [TC_W-1:0] i_mst_tc,
    input wire logic [SIZE_W-1:0] i_mst_size,
    input wire logic i_mst_rnw,
    input wire logic i_mst_end,
    output logic o_mst_busy,
    output logic o_mst_done,
    input wire logic i_addr_strobe_n,
    output logic o_addr_strobe_n,
    output logic o_addr_strobe_n_oe_n,
    input wire logic i_bus_owner_ack_n,
    output logic o_bus_owner_ack_n,
    output logic o_bus_owner_ack_n_oe_n,
    output logic o_bus_request_n,
    input wire logic i_bus_grant_n,
    input wire logic i_register_select_n,
    input wire logic i_bridge_select_n,
    input wire logic i_master_protocol_strap_n,
    input wire logic [ADDR_W-1:0] i_addr,
    output logic [ADDR_W-1:0] o_addr,
    output logic [TC_W-1:0] o_transfer_code,
    output logic [SIZE_W-1:0] o_transfer_size,
    output logic o_rnw,
    output logic o_qual_oe_n,
    output logic o_alt_protocol,
    output logic o_slv_reg_hit,
    output logic [REG_DEC_W-1:0] o_slv_reg_offset,
    output logic o_slv_bridge_hit,
    output logic [ADDR_W-1:0] o_slv_addr
);
    // ========================================================
    // Pin samplers
    logic [SLV_SYNC_W-1:0] slv_q;
    logic [ARB_SYNC_W-1:0] arb_q;
    logic strap_q;

    // Strobe, selects and address share one sampling edge
    lbs_pin_sync #(.W(SLV_SYNC_W)) u_slv_sync ( // [RULE5] [RULE15]
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sync_mode(1'b0),
        .i_d({i_addr, i_bridge_select_n, i_register_select_n, i_addr_strobe_n}),
        .o_q(slv_q)
    );

    // Grant and bus-owner inputs, double-sampled or synchronous
    lbs_pin_sync #(.W(ARB_SYNC_W)) u_arb_sync ( // [RULE10] [RULE12]
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sync_mode(i_sync_arb),
        .i_d({i_bus_owner_ack_n, i_bus_grant_n}),
        .o_q(arb_q)
    );

    lbs_pin_sync #(.W(1)) u_strap_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sync_mode(1'b0),
        .i_d(i_master_protocol_strap_n),
        .o_q(strap_q)
    );

    wire logic slv_strb_n = slv_q[SLV_STRB_POS];
    wire logic slv_reg_n = slv_q[SLV_REGSEL_POS];
    wire logic slv_br_n = slv_q[SLV_BRSEL_POS];
    wire logic [ADDR_W-1:0] slv_a = slv_q[SLV_ADDR_LSB +: ADDR_W];
    wire logic grant_n = arb_q[ARB_GRANT_POS];
    wire logic busy_in_n = arb_q[ARB_BUSY_POS];

    // ========================================================
    // Strap capture after reset release
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic alt_mode;
    logic next_alt_mode;

    // Pin is read only until settled, then frozen
    always_comb begin
        next_strap_cnt = strap_cnt;
        next_alt_mode = alt_mode;
        if (strap_cnt != STRAP_SETTLE) begin
            next_strap_cnt = strap_cnt + 2'h1;
            next_alt_mode = strap_q; // [RULE13]
        end
    end // later strap changes ignored [RULE14]

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            strap_cnt <= STRAP_CNT_RST;
            alt_mode <= 1'b0;
        end else begin
            strap_cnt <= next_strap_cnt;
            alt_mode <= next_alt_mode;
        end
    end

    // ========================================================
    // Master sequencer, rising edge
    lbs_state_t state;
    lbs_state_t next_state;
    logic req_n;
    logic next_req_n;
    logic qual_oe_n;
    logic next_qual_oe_n;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] next_addr_r;
    logic [TC_W-1:0] tc_r;
    logic [TC_W-1:0] next_tc_r;
    logic [SIZE_W-1:0] size_r;
    logic [SIZE_W-1:0] next_size_r;
    logic rnw_r;
    logic next_rnw_r;
    logic done;
    logic next_done;
    logic slv_active;

    // Bus must be idle (no owner, no foreign strobe) before owning it
    always_comb begin
        next_state = state;
        next_req_n = req_n;
        next_qual_oe_n = qual_oe_n;
        next_addr_r = addr_r;
        next_tc_r = tc_r;
        next_size_r = size_r;
        next_rnw_r = rnw_r;
        next_done = 1'b0;
        case (state)
            ST_IDLE: begin
                if (i_mst_req && !slv_active) begin
                    next_state = ST_REQ;
                    next_req_n = 1'b0; // [RULE11]
                end
            end
            ST_REQ: begin
                if (!grant_n && busy_in_n && slv_strb_n) begin
                    next_state = ST_OWN; // [RULE11]
                    next_req_n = PIN_NEGATED;
                end
            end
            ST_OWN: begin
                // Owner line went low on the last falling edge
                next_state = ST_ADDR;
                next_qual_oe_n = 1'b0; // [RULE3] [RULE18]
                next_addr_r = i_mst_addr;
                next_tc_r = i_mst_tc;
                next_size_r = i_mst_size;
                next_rnw_r = i_mst_rnw;
            end
            ST_ADDR: begin
                next_state = ST_STRB;
            end
            ST_STRB: begin
                if (i_mst_end) begin
                    next_state = ST_NEG;
                end
            end
            ST_NEG: begin
                next_state = ST_IDLE;
                next_qual_oe_n = OE_OFF_N;
                next_done = 1'b1;
            end
            default: begin
                next_state = ST_IDLE;
                next_req_n = PIN_NEGATED;
                next_qual_oe_n = OE_OFF_N;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            req_n <= PIN_NEGATED;
            qual_oe_n <= OE_OFF_N;
            addr_r <= '0;
            tc_r <= '0;
            size_r <= '0;
            rnw_r <= 1'b1;
            done <= 1'b0;
        end else begin
            state <= next_state;
            req_n <= next_req_n;
            qual_oe_n <= next_qual_oe_n;
            addr_r <= next_addr_r;
            tc_r <= next_tc_r;
            size_r <= next_size_r;
            rnw_r <= next_rnw_r;
            done <= next_done;
        end
    end

    wire logic mastering = (state == ST_OWN) || (state == ST_ADDR) ||
                           (state == ST_STRB) || (state == ST_NEG);

    // ========================================================
    // Falling-edge pin drivers for strobe and bus owner
    logic strb_n;
    logic next_strb_n;
    logic strb_oe_n;
    logic next_strb_oe_n;
    logic own_n;
    logic next_own_n;
    logic own_oe_n;
    logic next_own_oe_n;

    // NEG state drives high for one falling edge before release
    always_comb begin
        next_strb_oe_n = !((state == ST_ADDR) || (state == ST_STRB) ||
                           (state == ST_NEG)); // [RULE1]
        next_strb_n = !((state == ST_ADDR) || (state == ST_STRB)); // [RULE2] [RULE4]
        next_own_oe_n = !mastering;
        next_own_n = !((state == ST_OWN) || (state == ST_ADDR) ||
                       (state == ST_STRB)); // [RULE8] [RULE9]
    end

    always_ff @(negedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            strb_n <= PIN_NEGATED;
            strb_oe_n <= OE_OFF_N;
            own_n <= PIN_NEGATED;
            own_oe_n <= OE_OFF_N;
        end else begin
            strb_n <= next_strb_n;
            strb_oe_n <= next_strb_oe_n;
            own_n <= next_own_n;
            own_oe_n <= next_own_oe_n;
        end
    end

    // ========================================================
    // Slave qualification, at most one pulse per strobe
    logic slv_seen;
    logic next_slv_seen;
    logic reg_hit;
    logic next_reg_hit;
    logic br_hit;
    logic next_br_hit;
    logic [REG_DEC_W-1:0] reg_off;
    logic [REG_DEC_W-1:0] next_reg_off;
    logic [ADDR_W-1:0] slv_addr_r;
    logic [ADDR_W-1:0] next_slv_addr_r;

    assign slv_active = !slv_strb_n || slv_seen;

    // Selects may settle after strobe; only the first sample with a select while strobe is low counts
    always_comb begin
        next_slv_seen = slv_seen;
        next_reg_hit = 1'b0;
        next_br_hit = 1'b0;
        next_reg_off = reg_off;
        next_slv_addr_r = slv_addr_r;
        if (slv_strb_n) begin
            next_slv_seen = 1'b0;
        end else if (!slv_seen && !mastering && (!slv_reg_n || !slv_br_n)) begin // [RULE7]
            next_slv_seen = 1'b1;
            next_reg_hit = !slv_reg_n; // [RULE6]
            next_br_hit = slv_reg_n && !slv_br_n; // [RULE6] [RULE17]
            next_reg_off = slv_a[REG_DEC_W-1:0]; // [RULE16]
            next_slv_addr_r = slv_a; // [RULE15]
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            slv_seen <= 1'b0;
            reg_hit <= 1'b0;
            br_hit <= 1'b0;
            reg_off <= '0;
            slv_addr_r <= '0;
        end else begin
            slv_seen <= next_slv_seen;
            reg_hit <= next_reg_hit;
            br_hit <= next_br_hit;
            reg_off <= next_reg_off;
            slv_addr_r <= next_slv_addr_r;
        end
    end

    // ========================================================
    // Outputs
    assign o_addr_strobe_n = strb_n;
    assign o_addr_strobe_n_oe_n = strb_oe_n;
    assign o_bus_owner_ack_n = own_n;
    assign o_bus_owner_ack_n_oe_n = own_oe_n;
    assign o_bus_request_n = req_n;
    assign o_addr = addr_r;
    assign o_transfer_code = tc_r;
    assign o_transfer_size = size_r;
    assign o_rnw = rnw_r;
    assign o_qual_oe_n = qual_oe_n;
    assign o_alt_protocol = alt_mode;
    assign o_mst_busy = (state != ST_IDLE);
    assign o_mst_done = done;
    assign o_slv_reg_hit = reg_hit;
    assign o_slv_reg_offset = reg_off;
    assign o_slv_bridge_hit = br_hit;
    assign o_slv_addr = slv_addr_r;

    // ========================================================
    // Assertions
    property p_strobe_only_master;
        @(posedge i_clk) disable iff (!i_nrst) !strb_oe_n |-> mastering;
    endproperty
    a_strobe_only_master: assert property (p_strobe_only_master) // [RULE1]
        else $error("strobe driven while not master");

    property p_qual_before_strobe;
        @(posedge i_clk) disable iff (!i_nrst) $fell(strb_n) |-> !qual_oe_n && $past(qual_oe_n);
    endproperty
    a_qual_before_strobe: assert property (p_qual_before_strobe) // [RULE3]
        else $error("strobe asserted before qualifiers driven");

    property p_strobe_negate_first;
        @(posedge i_clk) disable iff (!i_nrst) $rose(strb_oe_n) |-> $past(strb_n);
    endproperty
    a_strobe_negate_first: assert property (p_strobe_negate_first) // [RULE4]
        else $error("strobe released while low");

    property p_owner_negate_first;
        @(posedge i_clk) disable iff (!i_nrst) $rose(own_oe_n) |-> $past(own_n);
    endproperty
    a_owner_negate_first: assert property (p_owner_negate_first) // [RULE9]
        else $error("bus owner released while low");

    property p_strobe_after_owner;
        @(posedge i_clk) disable iff (!i_nrst) !strb_n |-> !own_n && $past(!own_n);
    endproperty
    a_strobe_after_owner: assert property (p_strobe_after_owner) // [RULE18]
        else $error("strobe low without prior bus ownership");

    property p_owner_after_grant;
        @(posedge i_clk) disable iff (!i_nrst) $rose(state == ST_OWN) |-> $past(!grant_n);
    endproperty
    a_owner_after_grant: assert property (p_owner_after_grant) // [RULE11]
        else $error("ownership taken without grant");

    property p_slave_needs_select;
        @(posedge i_clk) disable iff (!i_nrst)
            (reg_hit || br_hit) |-> $past(!slv_strb_n && (!slv_reg_n || !slv_br_n) && !mastering);
    endproperty
    a_slave_needs_select: assert property (p_slave_needs_select) // [RULE6]
        else $error("slave hit without strobe and select");

    property p_reg_offset_low_bits;
        @(posedge i_clk) disable iff (!i_nrst) reg_hit |-> reg_off == slv_addr_r[REG_DEC_W-1:0];
    endproperty
    a_reg_offset_low_bits: assert property (p_reg_offset_low_bits) // [RULE16]
        else $error("register offset not low address bits");

    property p_strap_frozen;
        @(posedge i_clk) disable iff (!i_nrst) (strap_cnt == STRAP_SETTLE) |=> $stable(alt_mode);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) // [RULE14]
        else $error("protocol mode changed after reset");

    c_master_cycle: cover property (@(posedge i_clk) disable iff (!i_nrst) done);
    c_reg_hit: cover property (@(posedge i_clk) disable iff (!i_nrst) reg_hit);
    c_bridge_hit: cover property (@(posedge i_clk) disable iff (!i_nrst) br_hit);
    c_alt_mode: cover property (@(posedge i_clk) disable iff (!i_nrst) alt_mode);
endmodule // lbs_strobe_arb
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the local bus strobe and arbitration logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lbs_pkg::*;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic rs_n;
        logic bs_n;
        logic late;
        logic reg_hit;
        logic br_hit;
    } lbs_row_t;
    // Slave cases: address, selects, late select, expected hits
    lbs_row_t rows [5] = '{
        '{32'h1234_5abc, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
        '{32'h8000_0ffc, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
        '{32'h0000_0001, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{32'h7fff_f000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
        '{32'hdead_b123, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1}};
    logic i_clk = 1'b0, i_nrst = 1'b0, i_sync_arb = 1'b0, i_mst_req = 1'b0;
    logic [ADDR_W-1:0] i_mst_addr = '0;
    logic [TC_W-1:0] i_mst_tc = '0;
    logic [SIZE_W-1:0] i_mst_size = '0;
    logic i_mst_rnw = 1'b1, i_mst_end = 1'b0, strap_n = 1'b1;
    logic o_mst_busy, o_mst_done, o_addr_strobe_n, o_addr_strobe_n_oe_n, o_bus_owner_ack_n;
    logic o_bus_owner_ack_n_oe_n, o_bus_request_n, grant_n, strb_pin_n, owner_pin_n;
    logic regsel_n, brsel_n, o_rnw, o_qual_oe_n, o_alt_protocol, o_slv_reg_hit, o_slv_bridge_hit;
    logic [ADDR_W-1:0] addr_pin, o_addr, o_slv_addr;
    logic [TC_W-1:0] o_transfer_code;
    logic [SIZE_W-1:0] o_transfer_size;
    logic [REG_DEC_W-1:0] o_slv_reg_offset;
    int fails = 0, checked = 0, cycles = 0, nreg, nbr;

    lbs_strobe_arb lbs_strobe_arb_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_sync_arb(i_sync_arb),
        .i_mst_req(i_mst_req), .i_mst_addr(i_mst_addr), .i_mst_tc(i_mst_tc),
        .i_mst_size(i_mst_size), .i_mst_rnw(i_mst_rnw), .i_mst_end(i_mst_end),
        .o_mst_busy(o_mst_busy), .o_mst_done(o_mst_done), .i_addr_strobe_n(strb_pin_n),
        .o_addr_strobe_n(o_addr_strobe_n), .o_addr_strobe_n_oe_n(o_addr_strobe_n_oe_n),
        .i_bus_owner_ack_n(owner_pin_n), .o_bus_owner_ack_n(o_bus_owner_ack_n),
        .o_bus_owner_ack_n_oe_n(o_bus_owner_ack_n_oe_n), .o_bus_request_n(o_bus_request_n),
        .i_bus_grant_n(grant_n), .i_register_select_n(regsel_n), .i_bridge_select_n(brsel_n),
        .i_master_protocol_strap_n(strap_n), .i_addr(addr_pin), .o_addr(o_addr),
        .o_transfer_code(o_transfer_code), .o_transfer_size(o_transfer_size), .o_rnw(o_rnw),
        .o_qual_oe_n(o_qual_oe_n), .o_alt_protocol(o_alt_protocol),
        .o_slv_reg_hit(o_slv_reg_hit), .o_slv_reg_offset(o_slv_reg_offset),
        .o_slv_bridge_hit(o_slv_bridge_hit), .o_slv_addr(o_slv_addr));
    lbs_far_model lbs_far_model_i (.i_clk(i_clk), .i_bus_request_n(o_bus_request_n),
        .i_strobe_n(o_addr_strobe_n), .i_strobe_oe_n(o_addr_strobe_n_oe_n),
        .i_owner_n(o_bus_owner_ack_n), .i_owner_oe_n(o_bus_owner_ack_n_oe_n), .i_addr(o_addr),
        .i_qual_oe_n(o_qual_oe_n), .o_bus_grant_n(grant_n), .o_strobe_pin_n(strb_pin_n),
        .o_owner_pin_n(owner_pin_n), .o_addr_pin(addr_pin), .o_register_select_n(regsel_n),
        .o_bridge_select_n(brsel_n));

    // ========================================================
    // Clock and hang guard
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            summarize();
        end
    end

    // ========================================================
    // Helpers: settle just after an edge, compare, report
    task automatic rise();
        @(posedge i_clk) #1;
    endtask
    task automatic fall();
        @(negedge i_clk) #1;
    endtask
    task automatic check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ========================================================
    // One master cycle; watches both edges to see when the strobe moves
    task automatic master_cycle(input logic [ADDR_W-1:0] a, input logic [TC_W-1:0] tc,
                                input logic [SIZE_W-1:0] sz, input logic rnw);
        int n;
        logic q_ok;
        n = 0;
        @(negedge i_clk);
        i_mst_req <= 1'b1;
        i_mst_addr <= a;
        i_mst_tc <= tc;
        i_mst_size <= sz;
        i_mst_rnw <= rnw;
        do begin
            rise();
            if (n == 0) begin
                check(o_bus_request_n, 1'b0, "request raised");
            end
            q_ok = o_qual_oe_n === 1'b0 && o_addr === a && o_transfer_code === tc
                && o_transfer_size === sz && o_rnw === rnw && o_addr_strobe_n_oe_n === 1'b1;
            fall();
            n++;
        end while (o_addr_strobe_n_oe_n !== 1'b0 && n < 40);
        check(q_ok, 1'b1, "fields before strobe");
        check(o_addr_strobe_n, 1'b0, "strobe low at falling edge");
        check({o_bus_owner_ack_n_oe_n, o_bus_owner_ack_n}, 2'h0, "owner");
        check(o_bus_request_n, 1'b1, "request dropped after grant");
        repeat (3) rise();
        check({o_addr_strobe_n, o_mst_busy}, 2'h1, "strobe held until end");
        @(negedge i_clk);
        i_mst_end <= 1'b1;
        n = 0;
        do begin
            rise();
            n++;
        end while (o_mst_done !== 1'b1 && n < 10);
        check(o_mst_done, 1'b1, "done pulse");
        check({o_addr_strobe_n_oe_n, o_addr_strobe_n}, 2'h1, "strobe negated");
        check({o_bus_owner_ack_n_oe_n, o_bus_owner_ack_n}, 2'h1, "owner negated");
        @(negedge i_clk);
        i_mst_req <= 1'b0;
        i_mst_end <= 1'b0;
        fall();
        check({o_addr_strobe_n_oe_n, o_bus_owner_ack_n_oe_n}, 2'h3, "pins freed");
    endtask

    // ========================================================
    // Main sequence: reset, slave table, master cycles, awkward cases
    initial begin
        repeat (5) @(negedge i_clk);
        check({o_addr_strobe_n_oe_n, o_bus_owner_ack_n_oe_n, o_qual_oe_n}, 3'h7, "reset oe");
        i_nrst <= 1'b1;
        repeat (3) rise();
        check(o_alt_protocol, 1'b1, "strap high");
        @(negedge i_clk);
        strap_n <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            nreg = 0;
            nbr = 0;
            fork
                lbs_far_model_i.slave_cycle(rows[r].a, rows[r].rs_n, rows[r].bs_n, rows[r].late);
                repeat (14) begin
                    rise();
                    if (o_slv_reg_hit === 1'b1) begin
                        nreg++;
                        check(o_slv_reg_offset, rows[r].a[REG_DEC_W-1:0], "offset");
                    end
                    if (o_slv_bridge_hit === 1'b1) begin
                        nbr++;
                    end
                    if (o_slv_reg_hit === 1'b1 || o_slv_bridge_hit === 1'b1) begin
                        check(o_slv_addr, rows[r].a, "slave address");
                    end
                end
            join
            check(nreg, rows[r].reg_hit, "register hits");
            check(nbr, rows[r].br_hit, "bridge hits");
            check(o_addr_strobe_n_oe_n, 1'b1, "strobe free as slave");
        end
        check(o_alt_protocol, 1'b1, "strap ignored later");
        // Both arbitration sampling modes, prompt and slow grants
        for (int m = 0; m < 2; m++) begin
            @(negedge i_clk);
            i_sync_arb <= m[0];
            lbs_far_model_i.grant_dly = 3 * m;
            master_cycle(32'hc0de_0010 + m, 4'h5 + m[3:0], 2'h2 + m[1:0], m[0]);
        end
        // Grant arrives while someone else still holds the busy line
        @(negedge i_clk);
        lbs_far_model_i.ext_busy <= 1'b1;
        fork
            master_cycle(32'h0000_0ff0, 4'hf, 2'h3, 1'b0);
            begin
                repeat (8) rise();
                check({o_bus_owner_ack_n_oe_n, o_mst_busy}, 2'h3, "wait for busy");
                @(negedge i_clk);
                lbs_far_model_i.ext_busy <= 1'b0;
            end
        join
        // Second reset mid-run with the strap low
        @(negedge i_clk);
        i_nrst <= 1'b0;
        repeat (5) @(negedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) rise();
        check(o_alt_protocol, 1'b0, "strap low");
        master_cycle(32'hffff_ffff, 4'h0, 2'h0, 1'b1);
        summarize();
    end
endmodule // testbench
`default_nettype wire
